// file: rtl/cipa_cpu_if.sv
`timescale 1ns/10ps
`default_nettype none
module cipa_cpu_if #(
    parameter logic [cipa_pkg::CPU_W-1:0] LOCAL_CPU = 3'h0
) (
    input  wire logic                                 clock_in,
    input  wire logic                                 srst_in,
    input  wire logic                                 ce_in,
    input  wire logic [cipa_pkg::NUM_SPI-1:0]         spi_level_in,
    input  wire logic                                 cfg_wr_in,
    input  wire logic                                 cfg_rd_in,
    input  wire logic [cipa_pkg::IDX_W-1:0]           cfg_idx_in,
    input  wire cipa_pkg::cipa_cfg_word_t             cfg_wdata_in,
    input  wire logic [cipa_pkg::PRIO_W-1:0]          priority_mask_register_in,
    input  wire logic [cipa_pkg::BP_W-1:0]            binary_point_register_in,
    input  wire logic [cipa_pkg::BP_W-1:0]            aliased_binary_point_register_in,
    input  wire logic                                 ack_rd_in,
    input  wire logic                                 ack_alias_in,
    input  wire logic                                 eoi_wr_in,
    input  wire logic                                 split_eoi_in,
    input  wire logic                                 deact_wr_in,
    input  wire logic [cipa_pkg::ID_W-1:0]            eoi_id_in,
    input  wire logic                                 sgi_wr_in,
    input  wire logic                                 sgi_local_in,
    input  wire logic [cipa_pkg::CPU_W-1:0]           sgi_src_cpu_in,
    input  wire logic [2:0]                           sgi_num_in,
    input  wire logic [cipa_pkg::NUM_CPU-1:0]         sgi_targets_in,
    output logic                                      irq_out,
    output logic                                      ack_valid_out,
    output logic                                      ack_id_valid_out,
    output cipa_pkg::cipa_ack_word_t                  ack_word_out,
    output logic [cipa_pkg::PRIO_W-1:0]               running_prio_out,
    output logic                                      cfg_rd_valid_out,
    output cipa_pkg::cipa_cfg_word_t                  cfg_rdata_out
);
    localparam int unsigned N = cipa_pkg::NUM_IRQ;

    function automatic logic [cipa_pkg::ID_W-1:0] idx_to_id(input logic [cipa_pkg::IDX_W-1:0] idx);
        if (idx < cipa_pkg::IDX_W'(cipa_pkg::NUM_SGI)) begin
            idx_to_id = cipa_pkg::ID_W'(idx);
        end else begin
            idx_to_id = cipa_pkg::SPI_ID_BASE + cipa_pkg::ID_W'(idx - cipa_pkg::IDX_W'(cipa_pkg::NUM_SGI));
        end
    endfunction : idx_to_id

    // out-of-range ids decode as not found, so stray eoi writes are harmless
    function automatic logic id_to_idx(input  logic [cipa_pkg::ID_W-1:0]  id,
                                       output logic [cipa_pkg::IDX_W-1:0] idx);
        idx = '0;
        if (id < cipa_pkg::ID_W'(cipa_pkg::NUM_SGI)) begin
            idx = cipa_pkg::IDX_W'(id);
            id_to_idx = 1'b1;
        end else if (id >= cipa_pkg::SPI_ID_BASE &&
                     id < cipa_pkg::SPI_ID_BASE + cipa_pkg::ID_W'(cipa_pkg::NUM_SPI)) begin
            idx = cipa_pkg::IDX_W'(id - cipa_pkg::SPI_ID_BASE) + cipa_pkg::IDX_W'(cipa_pkg::NUM_SGI);
            id_to_idx = 1'b1;
        end else begin
            id_to_idx = 1'b0;
        end
    endfunction : id_to_idx

    function automatic logic [cipa_pkg::PRIO_W-1:0] group_prio(input logic [cipa_pkg::PRIO_W-1:0] p,
                                                              input logic [cipa_pkg::BP_W-1:0]   bp);
        group_prio = p & (cipa_pkg::IDLE_PRIO << (bp + 4'h1));
    endfunction : group_prio

    logic [N-1:0][cipa_pkg::PRIO_W-1:0]                   prio, next_prio;
    logic [N-1:0]                                         group1, next_group1;
    logic [cipa_pkg::NUM_SPI-1:0][cipa_pkg::NUM_CPU-1:0]  target, next_target;
    logic [cipa_pkg::NUM_SGI-1:0]                         sgi_pend, next_sgi_pend;
    logic [cipa_pkg::NUM_SGI-1:0][cipa_pkg::CPU_W-1:0]    sgi_src, next_sgi_src;
    logic [N-1:0]                                         active, next_active;
    logic [N-1:0]                                         held, next_held;
    logic [N-1:0][cipa_pkg::PRIO_W-1:0]                   held_grp;
    logic [cipa_pkg::PRIO_W-1:0]                          running_prio, next_running_prio;
    logic                                                 next_irq;
    logic                                                 next_ack_valid;
    logic                                                 next_ack_id_valid;
    cipa_pkg::cipa_ack_word_t                             next_ack_word;
    logic                                                 next_cfg_rd_valid;
    cipa_pkg::cipa_cfg_word_t                             next_cfg_rdata;

    logic [N-1:0]                                         pend_all;
    logic [N-1:0]                                         pend_g0;
    logic [N-1:0]                                         pend_g1;
    logic                                                 found_g0, found_g1;
    logic [cipa_pkg::IDX_W-1:0]                           idx_g0, idx_g1;
    logic [cipa_pkg::PRIO_W-1:0]                          prio_g0, prio_g1;
    logic                                                 suff_g0, suff_g1;
    logic [cipa_pkg::NUM_CPU-1:0]                         local_bit;

    assign local_bit = cipa_pkg::NUM_CPU'(1) << LOCAL_CPU;

    // active interrupts are not re-signalled until deactivated
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pend
            if (g < cipa_pkg::NUM_SGI) begin : g_sgi
                assign pend_all[g] = sgi_pend[g] && !active[g];
            end else begin : g_spi
                assign pend_all[g] = spi_level_in[g - cipa_pkg::NUM_SGI] &&
                                     target[g - cipa_pkg::NUM_SGI][LOCAL_CPU] && !active[g];
            end
            assign held_grp[g] = group_prio(prio[g], group1[g] ? aliased_binary_point_register_in
                                                               : binary_point_register_in);
        end
    endgenerate

    assign pend_g0 = pend_all & ~group1;
    assign pend_g1 = pend_all & group1;

    cipa_hp_select u_sel_g0 (
        .pend_in   (pend_g0),
        .prio_in   (prio),
        .found_out (found_g0),
        .idx_out   (idx_g0),
        .prio_out  (prio_g0)
    );

    cipa_hp_select u_sel_g1 (
        .pend_in   (pend_g1),
        .prio_in   (prio),
        .found_out (found_g1),
        .idx_out   (idx_g1),
        .prio_out  (prio_g1)
    );

    // sufficient priority: below mask and preempting the running group priority
    assign suff_g0 = found_g0 && prio_g0 < priority_mask_register_in &&
                     group_prio(prio_g0, binary_point_register_in) < running_prio;
    assign suff_g1 = found_g1 && prio_g1 < priority_mask_register_in &&
                     group_prio(prio_g1, aliased_binary_point_register_in) < running_prio;

    always_comb begin
        logic                         hit;
        logic [cipa_pkg::IDX_W-1:0]   e_idx;
        logic                         take;
        logic [cipa_pkg::IDX_W-1:0]   t_idx;
        logic [cipa_pkg::ID_W-1:0]    t_id;
        logic [cipa_pkg::IDX_W-1:0]   s_idx;
        hit   = 1'b0;
        e_idx = '0;
        take  = 1'b0;
        t_idx = '0;
        t_id  = cipa_pkg::SPURIOUS_ID;
        s_idx = '0;
        next_prio         = prio;
        next_group1       = group1;
        next_target       = target;
        next_sgi_pend     = sgi_pend;
        next_sgi_src      = sgi_src;
        next_active       = active;
        next_held         = held;
        next_ack_valid    = ack_rd_in;
        next_ack_word     = '{zero: cipa_pkg::ACK_ZERO_FIELD, src_cpu: '0,
                              id: cipa_pkg::SPURIOUS_ID};
        next_cfg_rd_valid = cfg_rd_in;
        next_cfg_rdata    = '0;

        // end of interrupt and deactivation; unknown ids are dropped, and end of interrupt also drops unheld ids
        hit = id_to_idx(eoi_id_in, e_idx);
        if (eoi_wr_in && hit && held[e_idx]) begin
            next_held[e_idx] = 1'b0;
            if (!split_eoi_in) begin
                next_active[e_idx] = 1'b0;
            end
        end
        if (deact_wr_in && hit) begin
            next_active[e_idx] = 1'b0;
            next_held[e_idx]   = 1'b0;
        end

        // acknowledge: each alias serves its own group only
        if (ack_rd_in) begin
            take  = ack_alias_in ? suff_g1 : suff_g0;
            t_idx = ack_alias_in ? idx_g1 : idx_g0;
        end
        if (take) begin
            t_id                 = idx_to_id(t_idx);
            next_active[t_idx]   = 1'b1;
            next_held[t_idx]     = 1'b1;
            next_ack_word.id     = t_id;
            if (t_idx < cipa_pkg::IDX_W'(cipa_pkg::NUM_SGI)) begin
                next_sgi_pend[t_idx[2:0]] = 1'b0;
                next_ack_word.src_cpu     = sgi_src[t_idx[2:0]];
            end
        end

        // software interrupt raise comes after the ack clear, so it wins
        if (sgi_wr_in && sgi_local_in && (sgi_targets_in & local_bit) != '0) begin
            next_sgi_pend[sgi_num_in] = 1'b1;
            next_sgi_src[sgi_num_in]  = sgi_src_cpu_in;
        end

        // configuration: only implemented fields take write data
        if (cfg_wr_in) begin
            next_prio[cfg_idx_in]   = cfg_wdata_in.prio & cipa_pkg::PRIO_IMPL_MASK;
            next_group1[cfg_idx_in] = cfg_wdata_in.group1;
            if (cfg_idx_in >= cipa_pkg::IDX_W'(cipa_pkg::NUM_SGI)) begin
                s_idx = cfg_idx_in - cipa_pkg::IDX_W'(cipa_pkg::NUM_SGI);
                next_target[s_idx[2:0]] = cfg_wdata_in.target;
            end
            // present and zero fields of the write data are discarded
        end
        if (cfg_rd_in) begin
            next_cfg_rdata.present = 1'b1;
            next_cfg_rdata.zero    = cipa_pkg::CFG_ZERO_FIELD;
            next_cfg_rdata.group1  = group1[cfg_idx_in];
            next_cfg_rdata.prio    = prio[cfg_idx_in] & cipa_pkg::PRIO_IMPL_MASK;
            if (cfg_idx_in >= cipa_pkg::IDX_W'(cipa_pkg::NUM_SGI)) begin
                s_idx = cfg_idx_in - cipa_pkg::IDX_W'(cipa_pkg::NUM_SGI);
                next_cfg_rdata.target = target[s_idx[2:0]];
            end else begin
                next_cfg_rdata.target = cipa_pkg::TARGET_SGI_RD;
            end
        end
    end

    assign next_ack_id_valid = ack_rd_in && (next_ack_word.id <= cipa_pkg::MAX_VALID_ID);

    // running priority tracks interrupts still awaiting end of interrupt
    always_comb begin
        next_running_prio = cipa_pkg::IDLE_PRIO;
        for (int i = 0; i < N; i++) begin
            if (next_held[i] && held_grp[i] < next_running_prio) begin
                next_running_prio = held_grp[i];
            end
        end
    end

    assign next_irq = suff_g0 || suff_g1;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            prio             <= {N{cipa_pkg::PRIO_RESET}};
            group1           <= '0;
            target           <= {cipa_pkg::NUM_SPI{cipa_pkg::TARGET_RESET}};
            sgi_pend         <= '0;
            sgi_src          <= '0;
            active           <= '0;
            held             <= '0;
            running_prio     <= cipa_pkg::IDLE_PRIO;
            irq_out          <= 1'b0;
            ack_valid_out    <= 1'b0;
            ack_id_valid_out <= 1'b0;
            ack_word_out     <= '{zero: cipa_pkg::ACK_ZERO_FIELD, src_cpu: '0,
                                  id: cipa_pkg::SPURIOUS_ID};
            cfg_rd_valid_out <= 1'b0;
            cfg_rdata_out    <= '0;
        end else if (ce_in) begin
            prio             <= next_prio;
            group1           <= next_group1;
            target           <= next_target;
            sgi_pend         <= next_sgi_pend;
            sgi_src          <= next_sgi_src;
            active           <= next_active;
            held             <= next_held;
            running_prio     <= next_running_prio;
            irq_out          <= next_irq;
            ack_valid_out    <= next_ack_valid;
            ack_id_valid_out <= next_ack_id_valid;
            ack_word_out     <= next_ack_word;
            cfg_rd_valid_out <= next_cfg_rd_valid;
            cfg_rdata_out    <= next_cfg_rdata;
        end
    end

    assign running_prio_out = running_prio;
endmodule : cipa_cpu_if
`default_nettype wire

// file: rtl/cipa_pkg.sv
package cipa_pkg;
    localparam int unsigned NUM_IRQ     = 16;
    localparam int unsigned NUM_SGI     = 8;
    localparam int unsigned NUM_SPI     = NUM_IRQ - NUM_SGI;
    localparam int unsigned IDX_W       = 4;
    localparam int unsigned ID_W        = 10;
    localparam int unsigned CPU_W       = 3;
    localparam int unsigned NUM_CPU     = 8;
    localparam int unsigned PRIO_W      = 8;
    localparam int unsigned BP_W        = 3;
    localparam int unsigned WORD_W      = 32;

    localparam logic [ID_W-1:0]   SPI_ID_BASE    = 10'h020;
    localparam logic [ID_W-1:0]   SPURIOUS_ID    = 10'h3ff;
    localparam logic [ID_W-1:0]   MAX_VALID_ID   = 10'h3fb;
    localparam logic [PRIO_W-1:0] IDLE_PRIO      = 8'hff;
    localparam logic [PRIO_W-1:0] PRIO_IMPL_MASK = 8'hf8;
    localparam logic [PRIO_W-1:0] PRIO_RESET     = 8'h00;
    localparam logic [PRIO_W-1:0] TARGET_RESET   = 8'h00;
    localparam logic [NUM_CPU-1:0] TARGET_SGI_RD = 8'h00;

    // acknowledge word: reserved top bits read as zero
    typedef struct packed {
        logic [WORD_W-ID_W-CPU_W-1:0] zero;
        logic [CPU_W-1:0]             src_cpu;
        logic [ID_W-1:0]              id;
    } cipa_ack_word_t;

    // per-interrupt configuration word
    typedef struct packed {
        logic                         present;
        logic [14:0]                  zero;
        logic                         group1;
        logic [NUM_CPU-1:0]           target;
        logic [PRIO_W-1:0]            prio;
    } cipa_cfg_word_t;

    localparam logic [14:0] CFG_ZERO_FIELD = 15'h0000;
    localparam logic [WORD_W-ID_W-CPU_W-1:0] ACK_ZERO_FIELD = 19'h00000;
endpackage : cipa_pkg

// file: rtl/cipa_hp_select.sv
`timescale 1ns/10ps
`default_nettype none
// picks the lowest priority value among pending entries, lowest index on ties
module cipa_hp_select (
    input  wire logic [cipa_pkg::NUM_IRQ-1:0]                    pend_in,
    input  wire logic [cipa_pkg::NUM_IRQ-1:0][cipa_pkg::PRIO_W-1:0] prio_in,
    output logic                                                 found_out,
    output logic      [cipa_pkg::IDX_W-1:0]                      idx_out,
    output logic      [cipa_pkg::PRIO_W-1:0]                     prio_out
);
    always_comb begin
        found_out = 1'b0;
        idx_out   = '0;
        prio_out  = cipa_pkg::IDLE_PRIO;
        for (int i = 0; i < cipa_pkg::NUM_IRQ; i++) begin
            if (pend_in[i] && (!found_out || prio_in[i] < prio_out)) begin
                found_out = 1'b1;
                idx_out   = cipa_pkg::IDX_W'(i);
                prio_out  = prio_in[i];
            end
        end
    end
endmodule : cipa_hp_select
`default_nettype wire

// file: bench/cipa_cpu_if_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module cipa_cpu_if_monitor (
    input wire logic                        clock_in,
    input wire logic                        srst_in,
    input wire logic                        ce_in,
    input wire logic                        cfg_rd_in,
    input wire logic                        ack_rd_in,
    input wire logic [cipa_pkg::PRIO_W-1:0] priority_mask_register_in,
    input wire logic                        irq_out,
    input wire logic                        ack_valid_out,
    input wire logic                        ack_id_valid_out,
    input wire cipa_pkg::cipa_ack_word_t    ack_word_out,
    input wire logic [cipa_pkg::PRIO_W-1:0] running_prio_out,
    input wire logic                        cfg_rd_valid_out,
    input wire cipa_pkg::cipa_cfg_word_t    cfg_rdata_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    sequence s_ack_req; ack_rd_in && ce_in; endsequence
    sequence s_cfg_req; cfg_rd_in && ce_in; endsequence
    sequence s_good_ack; ack_valid_out && ack_id_valid_out; endsequence
    a_ack_answered: assert property (s_ack_req |=> ack_valid_out)
        else $error("ack read not answered next cycle");
    a_ack_unasked: assert property (ack_valid_out |-> $past(ack_rd_in && ce_in))
        else $error("ack answer without a read");
    a_id_range: assert property (ack_valid_out |->
        ack_id_valid_out == (ack_word_out.id <= cipa_pkg::MAX_VALID_ID))
        else $error("id valid flag disagrees with id range");
    a_spurious_id: assert property (ack_valid_out && !ack_id_valid_out |->
        ack_word_out.id == cipa_pkg::SPURIOUS_ID)
        else $error("refused ack without spurious id");
    a_ack_reserved: assert property (ack_word_out.zero == cipa_pkg::ACK_ZERO_FIELD)
        else $error("ack word reserved bits not zero");
    a_cfg_fixed: assert property (s_cfg_req |=> cfg_rd_valid_out && cfg_rdata_out.present
        && cfg_rdata_out.zero == cipa_pkg::CFG_ZERO_FIELD)
        else $error("config read fixed fields wrong");
    a_prio_low: assert property (cfg_rd_valid_out |->
        (cfg_rdata_out.prio & ~cipa_pkg::PRIO_IMPL_MASK) == 8'h00)
        else $error("unimplemented priority bits not zero");
    a_running_raise: assert property (s_good_ack |-> running_prio_out != cipa_pkg::IDLE_PRIO)
        else $error("running priority idle after valid ack");
    a_running_form: assert property (running_prio_out == cipa_pkg::IDLE_PRIO ||
        (running_prio_out & ~cipa_pkg::PRIO_IMPL_MASK) == 8'h00)
        else $error("running priority neither idle nor a group priority");
    a_irq_mask: assert property ($rose(irq_out) |-> $past(priority_mask_register_in) != 8'h00)
        else $error("request raised under a full mask");
endmodule : cipa_cpu_if_monitor
bind cipa_cpu_if cipa_cpu_if_monitor i_mon (.clock_in, .srst_in, .ce_in, .cfg_rd_in, .ack_rd_in,
    .priority_mask_register_in, .irq_out, .ack_valid_out, .ack_id_valid_out, .ack_word_out,
    .running_prio_out, .cfg_rd_valid_out, .cfg_rdata_out);
`default_nettype wire

// file: bench/cipa_proc_model.sv
`timescale 1ns/10ps
`default_nettype none
// processor side: one-cycle strobes launched at the falling edge
module cipa_proc_model (
    input  wire logic                         clock_in,
    output logic                              cfg_wr_out,
    output logic                              cfg_rd_out,
    output logic [cipa_pkg::IDX_W-1:0]        cfg_idx_out,
    output cipa_pkg::cipa_cfg_word_t          cfg_wdata_out,
    output logic                              ack_rd_out,
    output logic                              ack_alias_out,
    output logic                              eoi_wr_out,
    output logic                              deact_wr_out,
    output logic [cipa_pkg::ID_W-1:0]         eoi_id_out,
    output logic                              sgi_wr_out,
    output logic                              sgi_local_out,
    output logic [cipa_pkg::CPU_W-1:0]        sgi_src_cpu_out,
    output logic [2:0]                        sgi_num_out,
    output logic [cipa_pkg::NUM_CPU-1:0]      sgi_targets_out
);
    initial begin
        {cfg_wr_out, cfg_rd_out, cfg_idx_out, cfg_wdata_out, ack_rd_out, ack_alias_out} = '0;
        {eoi_wr_out, deact_wr_out, eoi_id_out, sgi_wr_out, sgi_local_out, sgi_src_cpu_out} = '0;
        {sgi_num_out, sgi_targets_out} = '0;
    end
    task automatic pulse_end();
        @(negedge clock_in);
        {cfg_wr_out, cfg_rd_out, ack_rd_out, eoi_wr_out, deact_wr_out, sgi_wr_out} = 6'h00;
        // idle data toggles so a stale value is never mistaken for a request
        cfg_wdata_out = ~cfg_wdata_out;
        eoi_id_out = ~eoi_id_out;
    endtask : pulse_end
    task automatic cfg_access(input logic wr, input logic [3:0] idx, input cipa_pkg::cipa_cfg_word_t d);
        @(negedge clock_in);
        {cfg_wr_out, cfg_rd_out, cfg_idx_out, cfg_wdata_out} = {wr, !wr, idx, d};
        cfg_wdata_out.zero = cipa_pkg::CFG_ZERO_FIELD;
        pulse_end();
    endtask : cfg_access
    task automatic ack_read(input logic alias_sel);
        @(negedge clock_in);
        {ack_rd_out, ack_alias_out} = {1'b1, alias_sel};
        pulse_end();
    endtask : ack_read
    task automatic eoi_write(input logic dw, input logic [9:0] id);
        @(negedge clock_in);
        {eoi_wr_out, deact_wr_out, eoi_id_out} = {!dw, dw, id};
        pulse_end();
    endtask : eoi_write
    task automatic sgi_raise(input logic loc, input logic [2:0] src, num, input logic [7:0] tg);
        @(negedge clock_in);
        {sgi_wr_out, sgi_local_out, sgi_src_cpu_out, sgi_num_out, sgi_targets_out} =
            {1'b1, loc, src, num, tg};
        pulse_end();
    endtask : sgi_raise
endmodule : cipa_proc_model
`default_nettype wire

// file: bench/test_cpu_interface_priority_ack.sv
`timescale 1ns/10ps
`default_nettype none
module test_cpu_interface_priority_ack;
    logic                     clock_in = 1'b0;
    logic                     srst_in  = 1'b1;
    logic [7:0]               spi_level = 8'h00;
    logic [7:0]               pmr = 8'hff;
    logic                     ce = 1'b1, split = 1'b0, deact;
    logic                     cfg_wr, cfg_rd, ack_rd, ack_alias, eoi_wr, sgi_wr, sgi_local;
    logic                     irq, ack_valid, ack_id_valid, cfg_rd_valid;
    logic [3:0]               cfg_idx;
    logic [9:0]               eoi_id;
    logic [2:0]               sgi_src, sgi_num, num, src;
    logic [7:0]               sgi_tg, running;
    logic [31:0]              e, r;
    cipa_pkg::cipa_cfg_word_t cfg_wdata, cfg_rdata, cfg_q[$];
    cipa_pkg::cipa_ack_word_t ack_word;
    logic [31:0]              ack_q[$];
    int                       bad_count = 0, comparisons = 0, seed = 36;
    always #4 clock_in = ~clock_in;
    cipa_proc_model proc (.clock_in, .cfg_wr_out(cfg_wr), .cfg_rd_out(cfg_rd),
        .cfg_idx_out(cfg_idx), .cfg_wdata_out(cfg_wdata), .ack_rd_out(ack_rd),
        .ack_alias_out(ack_alias), .eoi_wr_out(eoi_wr), .deact_wr_out(deact),
        .eoi_id_out(eoi_id), .sgi_wr_out(sgi_wr),
        .sgi_local_out(sgi_local), .sgi_src_cpu_out(sgi_src), .sgi_num_out(sgi_num),
        .sgi_targets_out(sgi_tg));
    cipa_cpu_if i_cipa_cpu_if (.clock_in, .srst_in, .ce_in(ce), .spi_level_in(spi_level),
        .cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd), .cfg_idx_in(cfg_idx), .cfg_wdata_in(cfg_wdata),
        .priority_mask_register_in(pmr), .binary_point_register_in(3'h0),
        .aliased_binary_point_register_in(3'h0), .ack_rd_in(ack_rd), .ack_alias_in(ack_alias),
        .eoi_wr_in(eoi_wr), .split_eoi_in(split), .deact_wr_in(deact), .eoi_id_in(eoi_id),
        .sgi_wr_in(sgi_wr), .sgi_local_in(sgi_local), .sgi_src_cpu_in(sgi_src),
        .sgi_num_in(sgi_num), .sgi_targets_in(sgi_tg), .irq_out(irq), .ack_valid_out(ack_valid),
        .ack_id_valid_out(ack_id_valid), .ack_word_out(ack_word), .running_prio_out(running),
        .cfg_rd_valid_out(cfg_rd_valid), .cfg_rdata_out(cfg_rdata));
    task automatic check(input string what, input logic [32:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    task automatic expect_ack(input logic alias_sel, input logic [2:0] s, input logic [9:0] id);
        ack_q.push_back({19'h00000, s, id});
        proc.ack_read(alias_sel);
    endtask : expect_ack
    task automatic read_cfg(input logic [3:0] idx, input cipa_pkg::cipa_cfg_word_t exp);
        cfg_q.push_back(exp);
        proc.cfg_access(1'b0, idx, '0);
    endtask : read_cfg
    // fixed settle span: pending takes one edge, the request one more
    task automatic irq_is(input logic exp);
        repeat (3) @(negedge clock_in);
        check("irq", {32'h0, irq}, {32'h0, exp});
    endtask : irq_is
    task automatic run_is(input logic [7:0] exp);
        repeat (2) @(negedge clock_in);
        check("running", {25'h0, running}, {25'h0, exp});
    endtask : run_is
    always @(negedge clock_in) begin
        if (ack_valid === 1'b1) begin
            e = (ack_q.size() > 0) ? ack_q.pop_front() : 32'hffffffff;
            check("ack word", {1'b0, ack_word}, {1'b0, e});
            check("ack id valid", {32'h0, ack_id_valid}, {32'h0, e[9:0] <= 10'h3fb});
        end
        if (cfg_rd_valid === 1'b1)
            check("cfg read", cfg_rdata, (cfg_q.size() > 0) ? cfg_q.pop_front() : '1);
    end
    initial begin
        repeat (5000) @(posedge clock_in);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(negedge clock_in);
        srst_in = 1'b0;
        r = $random(seed);
        proc.cfg_access(1'b1, 4'h8, {r[0], 15'h0, 1'b0, 8'h01, 8'h47});
        read_cfg(4'h8, {1'b1, 15'h0, 1'b0, 8'h01, 8'h40});
        proc.cfg_access(1'b1, 4'h9, {1'b0, 15'h0, 1'b0, 8'h02, 8'h80});
        proc.cfg_access(1'b1, 4'ha, {1'b0, 15'h0, 1'b0, 8'h01, 8'h20});
        proc.cfg_access(1'b1, 4'h3, {1'b0, 15'h0, 1'b0, 8'hff, 8'h60});
        read_cfg(4'h3, {1'b1, 15'h0, 1'b0, 8'h00, 8'h60});
        expect_ack(1'b0, 3'h0, 10'h3ff);
        spi_level = 8'h02;
        irq_is(1'b0);
        expect_ack(1'b0, 3'h0, 10'h3ff);
        spi_level = 8'h01;
        irq_is(1'b1);
        spi_level = 8'h00;
        expect_ack(1'b0, 3'h0, 10'h3ff);
        pmr = 8'h40;
        spi_level = 8'h01;
        irq_is(1'b0);
        pmr = 8'hff;
        irq_is(1'b1);
        expect_ack(1'b1, 3'h0, 10'h3ff);
        expect_ack(1'b0, 3'h0, 10'h020);
        run_is(8'h40);
        spi_level = 8'h05;
        irq_is(1'b1);
        expect_ack(1'b0, 3'h0, 10'h022);
        run_is(8'h20);
        spi_level = 8'h00;
        proc.eoi_write(1'b0, 10'h022);
        run_is(8'h40);
        proc.eoi_write(1'b0, 10'h020);
        run_is(8'hff);
        // enable low freezes the request output even with a fresh level
        ce = 1'b0;
        spi_level = 8'h01;
        irq_is(1'b0);
        ce = 1'b1;
        irq_is(1'b1);
        spi_level = 8'h00;
        r = $random(seed);
        {src, num} = r[5:0];
        proc.sgi_raise(1'b0, src, num, 8'h01);
        irq_is(1'b0);
        proc.sgi_raise(1'b1, src, num, 8'hfe);
        irq_is(1'b0);
        expect_ack(1'b0, 3'h0, 10'h3ff);
        proc.sgi_raise(1'b1, src, num, 8'h01);
        irq_is(1'b1);
        expect_ack(1'b0, src, {7'h00, num});
        run_is((num == 3'h3) ? 8'h60 : 8'h00);
        split = 1'b1;
        proc.eoi_write(1'b0, {7'h00, num});
        run_is(8'hff);
        // still active after the drop, so a new raise waits for deactivation
        proc.sgi_raise(1'b1, src, num, 8'h01);
        irq_is(1'b0);
        proc.eoi_write(1'b1, {7'h00, num});
        irq_is(1'b1);
        split = 1'b0;
        expect_ack(1'b0, src, {7'h00, num});
        proc.eoi_write(1'b0, {7'h00, num});
        run_is(8'hff);
        check("queues left", 33'(ack_q.size() + cfg_q.size()), 33'h0);
        tally_and_finish();
    end
endmodule : test_cpu_interface_priority_ack
`default_nettype wire
